// >>> inc/sssf_map.vh
// Register map, field positions and reset values of the serial port status block.
`ifndef SSSF_MAP_VH
`define SSSF_MAP_VH

// Register byte offsets on the plain register port.
`define SSSF_ADDR_W          5
`define SSSF_ADDR_CTRL       5'h00
`define SSSF_ADDR_STATUS     5'h04
`define SSSF_ADDR_DATA       5'h08
`define SSSF_ADDR_IRQ_STAT   5'h0C
`define SSSF_ADDR_IRQ_MASK   5'h10

// Control register fields.
`define SSSF_CTRL_ON         0
`define SSSF_CTRL_ENH        1
`define SSSF_CTRL_FRM        2
`define SSSF_CTRL_W          3
`define SSSF_CTRL_RST        3'h0

// Status register fields.
`define SSSF_ST_RXCNT_LSB    24
`define SSSF_ST_TXCNT_LSB    16
`define SSSF_ST_FRAMING_ERROR_FLAG       12
`define SSSF_ST_BUSY         11
`define SSSF_ST_TUR          8
`define SSSF_ST_SHIFTER_EMPTY_FLAG         7
`define SSSF_ST_ROV          6
`define SSSF_ST_RBE          5
`define SSSF_ST_TBE          3
`define SSSF_ST_TBF          1
`define SSSF_ST_RBF          0
`define SSSF_STATUS_RST      32'h0000_0008

// Interrupt status and mask fields.
`define SSSF_IRQ_W           4
`define SSSF_IRQ_ROV         0
`define SSSF_IRQ_TUR         1
`define SSSF_IRQ_FRAMING_ERROR_FLAG      2
`define SSSF_IRQ_RXWORD      3
`define SSSF_IRQ_RST         4'h0

// Buffer geometry.
`define SSSF_WORD_W          8
`define SSSF_DEPTH           16
`define SSSF_AW              4
`define SSSF_PW              5
`define SSSF_CNT_W           5
`define SSSF_BITS_LAST       3'h7

`endif

// >>> rtl/sssf_mem.v
// Small word memory with one write port and a registered read port.
`timescale 1ns/1ps
`include "sssf_map.vh"

module sssf_mem (
    input  wire                      core_clk,   // Module clock.
    input  wire                      rst,        // Asynchronous reset, active high.
    input  wire                      wr_en,      // Write strobe.
    input  wire [`SSSF_AW-1:0]       wr_addr,    // Write address.
    input  wire [`SSSF_WORD_W-1:0]   wr_data,    // Write data.
    input  wire [`SSSF_AW-1:0]       rd_addr,    // Read address, sampled every edge.
    output wire [`SSSF_WORD_W-1:0]   rd_data     // Registered read data.
);

    reg [`SSSF_WORD_W-1:0] mem_r [0:`SSSF_DEPTH-1];  // Storage array, no reset needed.
    reg [`SSSF_WORD_W-1:0] rd_data_r;                // Read data register.

    // The array is written on the strobe; it holds no control state.
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // The read data register follows the read address one edge later.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= {`SSSF_WORD_W{1'b0}};
        end else begin
            rd_data_r <= mem_r[rd_addr];
        end
    end

    assign rd_data = rd_data_r;

endmodule

// >>> rtl/sssf_status.v
// Serial port with buffers, a slave shifter and the status, flag and interrupt registers.
`timescale 1ns/1ps
`include "sssf_map.vh"

//Contract
// - Report receive buffer element count, five bits.
// - Report transmit buffer element count, five bits.
// - Frame error flag set by hardware, cleared by software.
// - Activity flag high while a transaction runs.
// - Underrun flag in framed mode; disable or zero-write clears.
// - Flag shows whether the shift register is empty; the code shows this flag in enhanced mode only and reads it as zero otherwise.
// - Overflow sets flag and discards the new word.
// - Overflow cleared only by disable or zero-write.
// - Receive empty exactly when read equals write pointer; the code shows this flag in enhanced mode only and reads it as zero otherwise.
// - Unimplemented status bits read as zero.
module sssf_status (
    input  wire                      core_clk,    // Module clock, 100 MHz.
    input  wire                      rst,         // Asynchronous reset, active high.
    input  wire [`SSSF_ADDR_W-1:0]   reg_addr,    // Register byte address.
    input  wire [31:0]               reg_wdata,   // Register write data.
    input  wire                      reg_wr,      // Write strobe.
    input  wire                      reg_rd,      // Read strobe.
    output wire [31:0]               reg_rdata,   // Read data, valid the cycle after the strobe.
    output wire                      irq,         // Level interrupt.
    input  wire                      spi_sclk,    // Serial clock from the bus master.
    input  wire                      spi_mosi,    // Serial data in.
    input  wire                      spi_ss_n,    // Slave select or frame sync, active low.
    output wire                      spi_miso,    // Serial data out.
    output wire                      spi_miso_oe  // High while the block drives serial data out.
);

    localparam [`SSSF_PW-1:0]   PTR_ONE   = 5'h01;          // Pointer increment.
    localparam [`SSSF_CNT_W-1:0] CNT_FULL = 5'h10;          // Element count of a full buffer.
    localparam [2:0]            BIT_ONE   = 3'h1;           // Bit counter increment.

    // Pin synchronisers: index 0 clock, 1 data, 2 select.
    reg  [2:0]                  pin_s1_r;                   // First stage, read only by the second.
    reg  [2:0]                  pin_s2_r;                   // Second stage.
    reg                         sclk_d_r;                   // Delayed clock for edge finding.
    wire [2:0]                  pin_raw = {spi_ss_n, spi_mosi, spi_sclk};

    // Control and software registers.
    reg  [`SSSF_CTRL_W-1:0]     ctrl_r;                     // On, enhanced buffer, framed mode.
    reg  [`SSSF_IRQ_W-1:0]      irq_stat_r;                 // Sticky event bits.
    reg  [`SSSF_IRQ_W-1:0]      irq_mask_r;                 // Interrupt enables.
    reg                         irq_r;                      // Interrupt output register.
    reg  [31:0]                 rdata_r;                    // Read data register.
    reg                         rov_r;                      // Receive overflow flag.
    reg                         tur_r;                      // Transmit underrun flag.
    reg                         ferr_r;                     // Frame error flag.
    reg                         busy_r;                     // Activity flag.

    // Buffer pointers; the visible write pointer trails by one edge so that the
    // registered memory read has caught the word before it is counted.
    reg  [`SSSF_PW-1:0]         rx_wr_r, rx_vis_r, rx_rd_r;
    reg  [`SSSF_PW-1:0]         tx_wr_r, tx_vis_r, tx_rd_r;

    // Shifter state.
    reg  [`SSSF_WORD_W-1:0]     rx_sh_r;                    // Receive shift register.
    reg  [`SSSF_WORD_W-1:0]     tx_sh_r;                    // Transmit shift register.
    reg  [2:0]                  bit_cnt_r;                  // Bits taken in the current word.
    reg                         loaded_r;                   // Shifter holds a word.
    reg                         miso_oe_r;                  // Output enable register.

    wire                        on_w   = ctrl_r[`SSSF_CTRL_ON];
    wire                        enh_w  = ctrl_r[`SSSF_CTRL_ENH];
    wire                        frm_w  = ctrl_r[`SSSF_CTRL_FRM];
    wire                        sclk_s = pin_s2_r[0];
    wire                        mosi_s = pin_s2_r[1];
    wire                        sel_s  = ~pin_s2_r[2];
    wire                        rise_w = sclk_s & ~sclk_d_r;
    wire                        fall_w = ~sclk_s & sclk_d_r;

    // Counts and buffer conditions.
    wire [`SSSF_CNT_W-1:0]      rx_cnt  = rx_vis_r - rx_rd_r;
    wire [`SSSF_CNT_W-1:0]      tx_cnt  = tx_vis_r - tx_rd_r;
    wire [`SSSF_CNT_W-1:0]      rx_room = rx_wr_r - rx_rd_r;
    wire [`SSSF_CNT_W-1:0]      tx_room = tx_wr_r - tx_rd_r;
    wire                        rx_empty = (rx_rd_r == rx_vis_r);
    wire                        tx_empty = (tx_rd_r == tx_vis_r);
    // Outside enhanced mode each buffer holds one word only.
    wire                        rx_full  = enh_w ? (rx_cnt == CNT_FULL) : (rx_cnt != 5'h00);
    wire                        tx_full  = enh_w ? (tx_cnt == CNT_FULL) : (tx_cnt != 5'h00);
    wire                        rx_nofit = enh_w ? (rx_room == CNT_FULL) : (rx_room != 5'h00);
    wire                        tx_nofit = enh_w ? (tx_room == CNT_FULL) : (tx_room != 5'h00);

    // Bus decode.
    wire                        wr_ctrl  = reg_wr & (reg_addr == `SSSF_ADDR_CTRL);
    wire                        wr_stat  = reg_wr & (reg_addr == `SSSF_ADDR_STATUS);
    wire                        wr_data  = reg_wr & (reg_addr == `SSSF_ADDR_DATA);
    wire                        wr_istat = reg_wr & (reg_addr == `SSSF_ADDR_IRQ_STAT);
    wire                        wr_imask = reg_wr & (reg_addr == `SSSF_ADDR_IRQ_MASK);
    wire                        rd_data  = reg_rd & (reg_addr == `SSSF_ADDR_DATA);

    // Buffer pushes and pops.
    wire                        tx_push  = on_w & wr_data & ~tx_nofit;
    wire                        rx_pop   = on_w & rd_data & ~rx_empty;
    wire                        start_w  = on_w & sel_s & ~loaded_r;
    wire                        tx_pop   = start_w & ~tx_empty;
    wire                        word_end = on_w & sel_s & loaded_r & rise_w & (bit_cnt_r == `SSSF_BITS_LAST);
    wire [`SSSF_WORD_W-1:0]     rx_word  = {rx_sh_r[`SSSF_WORD_W-2:0], mosi_s};
    wire                        rx_push  = word_end & ~rx_nofit;
    wire                        rov_evt  = word_end & rx_nofit;
    wire                        tur_evt  = start_w & tx_empty & frm_w;
    wire                        ferr_evt = on_w & frm_w & ~sel_s & (bit_cnt_r != 3'h0);
    wire [`SSSF_IRQ_W-1:0]      evt_w    = {rx_push, ferr_evt, tur_evt, rov_evt};

    // Next read pointers feed the memories so that read data track each pop.
    wire [`SSSF_PW-1:0]         rx_rd_nxt = on_w ? (rx_pop ? rx_rd_r + PTR_ONE : rx_rd_r) : 5'h00;
    wire [`SSSF_PW-1:0]         tx_rd_nxt = on_w ? (tx_pop ? tx_rd_r + PTR_ONE : tx_rd_r) : 5'h00;
    wire [`SSSF_WORD_W-1:0]     rx_q;                       // Head word of the receive buffer.
    wire [`SSSF_WORD_W-1:0]     tx_q;                       // Head word of the transmit buffer.

    // Sticky interrupt bits: a new event wins over a write-one clear.
    wire [`SSSF_IRQ_W-1:0]      irq_stat_nxt = (irq_stat_r & ~(wr_istat ? reg_wdata[`SSSF_IRQ_W-1:0]
                                               : {`SSSF_IRQ_W{1'b0}})) | evt_w;

    // Status word; every position not listed below stays zero.
    reg  [31:0]                 status_w;

    // Assemble the status word; enhanced-only flags read zero outside that mode.
    always @* begin
        status_w = 32'h0000_0000;
        status_w[`SSSF_ST_RXCNT_LSB +: `SSSF_CNT_W] = rx_cnt;
        status_w[`SSSF_ST_TXCNT_LSB +: `SSSF_CNT_W] = tx_cnt;
        status_w[`SSSF_ST_FRAMING_ERROR_FLAG] = ferr_r;
        status_w[`SSSF_ST_BUSY]   = busy_r;
        status_w[`SSSF_ST_TUR]    = tur_r;
        status_w[`SSSF_ST_SHIFTER_EMPTY_FLAG]   = enh_w & ~loaded_r;
        status_w[`SSSF_ST_ROV]    = rov_r;
        status_w[`SSSF_ST_RBE]    = enh_w & rx_empty;
        status_w[`SSSF_ST_TBE]    = tx_empty;
        status_w[`SSSF_ST_TBF]    = tx_full;
        status_w[`SSSF_ST_RBF]    = rx_full;
    end

    // Two flip-flops on each pin; they reset to idle levels, so no false edge follows.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    pin_s1_r[gi] <= (gi == 2);
                    pin_s2_r[gi] <= (gi == 2);
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                end
            end
        end
    endgenerate

    // Software registers, the bus read port and the interrupt output.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r     <= `SSSF_CTRL_RST;
            irq_stat_r <= `SSSF_IRQ_RST;
            irq_mask_r <= `SSSF_IRQ_RST;
            irq_r      <= 1'b0;
            rdata_r    <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata[`SSSF_CTRL_W-1:0];
            end
            if (wr_imask) begin
                irq_mask_r <= reg_wdata[`SSSF_IRQ_W-1:0];
            end
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= |(irq_stat_nxt & (wr_imask ? reg_wdata[`SSSF_IRQ_W-1:0] : irq_mask_r));
            // Read data stand for the one cycle after the strobe; unmapped reads give zero.
            if (reg_rd) begin
                case (reg_addr)
                    `SSSF_ADDR_CTRL:     rdata_r <= {29'h000_0000, ctrl_r};
                    `SSSF_ADDR_STATUS:   rdata_r <= status_w;
                    `SSSF_ADDR_DATA:     rdata_r <= rx_empty ? 32'h0000_0000 : {24'h00_0000, rx_q};
                    `SSSF_ADDR_IRQ_STAT: rdata_r <= {28'h000_0000, irq_stat_r};
                    `SSSF_ADDR_IRQ_MASK: rdata_r <= {28'h000_0000, irq_mask_r};
                    default:             rdata_r <= 32'h0000_0000;
                endcase
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    // Sticky status flags: set wins, a zero written clears, disabling clears overflow and underrun only.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rov_r  <= 1'b0;
            tur_r  <= 1'b0;
            ferr_r <= 1'b0;
        end else begin
            if (rov_evt) begin
                rov_r <= 1'b1;
            end else if (~on_w | (wr_stat & ~reg_wdata[`SSSF_ST_ROV])) begin
                rov_r <= 1'b0;
            end
            if (tur_evt) begin
                tur_r <= 1'b1;
            end else if (~on_w | (wr_stat & ~reg_wdata[`SSSF_ST_TUR])) begin
                tur_r <= 1'b0;
            end
            if (ferr_evt) begin
                ferr_r <= 1'b1;
            end else if (wr_stat & ~reg_wdata[`SSSF_ST_FRAMING_ERROR_FLAG]) begin
                ferr_r <= 1'b0;
            end
        end
    end

    // Buffer pointers; disabling the port empties both buffers.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_wr_r  <= 5'h00;
            rx_vis_r <= 5'h00;
            rx_rd_r  <= 5'h00;
            tx_wr_r  <= 5'h00;
            tx_vis_r <= 5'h00;
            tx_rd_r  <= 5'h00;
        end else if (~on_w) begin
            rx_wr_r  <= 5'h00;
            rx_vis_r <= 5'h00;
            rx_rd_r  <= 5'h00;
            tx_wr_r  <= 5'h00;
            tx_vis_r <= 5'h00;
            tx_rd_r  <= 5'h00;
        end else begin
            // A completed word is dropped when there is no room for it.
            if (rx_push) begin
                rx_wr_r <= rx_wr_r + PTR_ONE;
            end
            if (tx_push) begin
                tx_wr_r <= tx_wr_r + PTR_ONE;
            end
            rx_vis_r <= rx_wr_r;
            tx_vis_r <= tx_wr_r;
            rx_rd_r  <= rx_rd_nxt;
            tx_rd_r  <= tx_rd_nxt;
        end
    end

    // Slave shifter, mode 0: sample on the rising edge, change on the falling edge.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_d_r  <= 1'b0;
            rx_sh_r   <= 8'h00;
            tx_sh_r   <= 8'h00;
            bit_cnt_r <= 3'h0;
            loaded_r  <= 1'b0;
            miso_oe_r <= 1'b0;
            busy_r    <= 1'b0;
        end else begin
            sclk_d_r  <= sclk_s;
            miso_oe_r <= on_w & sel_s;
            busy_r    <= on_w & (sel_s | loaded_r | (bit_cnt_r != 3'h0));
            if (~on_w | ~sel_s) begin
                // Deselect ends the word; a partial word is abandoned.
                bit_cnt_r <= 3'h0;
                loaded_r  <= 1'b0;
            end else if (~loaded_r) begin
                // Load the next word, or zeros when the buffer has run dry.
                tx_sh_r  <= tx_empty ? 8'h00 : tx_q;
                loaded_r <= 1'b1;
            end else if (rise_w) begin
                rx_sh_r   <= rx_word;
                bit_cnt_r <= bit_cnt_r + BIT_ONE;
                if (bit_cnt_r == `SSSF_BITS_LAST) begin
                    loaded_r <= 1'b0;
                end
            end else if (fall_w & (bit_cnt_r != 3'h0)) begin
                tx_sh_r <= {tx_sh_r[`SSSF_WORD_W-2:0], 1'b0};
            end
        end
    end

    // Receive buffer storage.
    sssf_mem u_rx_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (rx_push),
        .wr_addr  (rx_wr_r[`SSSF_AW-1:0]),
        .wr_data  (rx_word),
        .rd_addr  (rx_rd_nxt[`SSSF_AW-1:0]),
        .rd_data  (rx_q)
    );

    // Transmit buffer storage.
    sssf_mem u_tx_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (tx_push),
        .wr_addr  (tx_wr_r[`SSSF_AW-1:0]),
        .wr_data  (reg_wdata[`SSSF_WORD_W-1:0]),
        .rd_addr  (tx_rd_nxt[`SSSF_AW-1:0]),
        .rd_data  (tx_q)
    );

    assign reg_rdata   = rdata_r;
    assign irq         = irq_r;
    assign spi_miso    = tx_sh_r[`SSSF_WORD_W-1];
    assign spi_miso_oe = miso_oe_r;

endmodule

// >>> sim/sssf_status_assertions.sv
// Concurrent checks on the ports of the serial port status block.
`timescale 1ns/1ps
`include "sssf_map.vh"

module sssf_status_chk (
    input wire                    core_clk,
    input wire                    rst,
    input wire [`SSSF_ADDR_W-1:0] reg_addr,
    input wire [31:0]             reg_wdata,
    input wire                    reg_wr,
    input wire                    reg_rd,
    input wire [31:0]             reg_rdata,
    input wire                    irq,
    input wire                    spi_sclk,
    input wire                    spi_mosi,
    input wire                    spi_ss_n,
    input wire                    spi_miso,
    input wire                    spi_miso_oe
);
    reg  st_q, enh_q;                                        // Status answer cycle; enhanced mode as written.
    wire st_wr = reg_wr && (reg_addr == `SSSF_ADDR_STATUS);  // Software write to the status register.
    wire ct_off = reg_wr && (reg_addr == `SSSF_ADDR_CTRL) && !reg_wdata[`SSSF_CTRL_ON]; // Port switched off.

    // Marks the cycle whose read data carry the status word.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= 1'b0;
            enh_q <= 1'b0;
        end else begin
            st_q <= reg_rd && (reg_addr == `SSSF_ADDR_STATUS);
            if (reg_wr && (reg_addr == `SSSF_ADDR_CTRL)) begin
                enh_q <= reg_wdata[`SSSF_CTRL_ENH];
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    a_status_unimpl_zero: assert property (st_q |-> (reg_rdata & 32'hE0E0_E614) == 32'h0000_0000)
        else $error("unimplemented status bit reads one");
    a_count_in_range: assert property (st_q |-> reg_rdata[28:24] <= 5'h10 && reg_rdata[20:16] <= 5'h10)
        else $error("element count beyond buffer depth");
    a_busy_when_loaded: assert property (st_q && enh_q && !reg_rdata[7] |-> reg_rdata[11])
        else $error("loaded shifter without activity flag");
    a_ovf_zero_clear: assert property (st_wr && !reg_wdata[6] ##[2:4] st_q |-> !reg_rdata[6])
        else $error("overflow flag survived a zero write");
    a_framing_error_flag_zero_clear: assert property (st_wr && !reg_wdata[12] ##[2:4] st_q |-> !reg_rdata[12])
        else $error("frame error flag survived a zero write");
    a_tur_zero_clear: assert property (st_wr && !reg_wdata[8] ##[2:4] st_q |-> !reg_rdata[8])
        else $error("underrun flag survived a zero write");
    a_oe_idle_low: assert property (spi_ss_n [*4] |-> !spi_miso_oe)
        else $error("data out driven without select");
    a_oe_off_low: assert property (ct_off |-> ##2 !spi_miso_oe)
        else $error("data out driven while port off");
endmodule

bind sssf_status sssf_status_chk sssf_status_chk_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_ss_n(spi_ss_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
);

// >>> sim/sssf_spi_master.sv
// Serial bus master model: frames words, clocks them at 160 ns per bit, mode 0.
`timescale 1ns/1ps

module sssf_spi_master (
    output reg  sclk,  // Serial clock, still and low outside frames.
    output reg  mosi,  // Serial data toward the block.
    output reg  ss_n,  // Select, high outside frames.
    input  wire miso   // Serial data from the block.
);
    // Idle bus from time zero.
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end

    // Sends the top nbits of tx, most significant first; a short count abandons the word.
    task xfer(input [7:0] tx, input integer nbits, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            #3 ss_n = 1'b0;
            #80;
            for (i = 7; i > 7 - nbits; i = i - 1) begin
                mosi = tx[i];
                #80 sclk = 1'b1;
                rx[i] = miso;
                #80 sclk = 1'b0;
            end
            #80 ss_n = 1'b1;
            mosi = ~mosi;  // Released line no longer shows the last bit.
            #160;
        end
    endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the serial port status block against a serial master model.
`timescale 1ns/1ps
`include "sssf_map.vh"

module tb_top;
    logic                    core_clk, rst, reg_wr, reg_rd;   // Clock, reset and strobes.
    logic [`SSSF_ADDR_W-1:0] reg_addr;                        // Register address.
    logic [31:0]             reg_wdata, d;                    // Write data and last read value.
    wire  [31:0]             reg_rdata;                       // Read data.
    wire                     irq, spi_sclk, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe;
    logic [7:0]              rxb;                             // Byte returned on the link.
    logic [36:0]             rows [0:5];                      // Address beside expected reset value.
    integer                  n_fail, n_checks, k;             // Counters and row index.

    sssf_status sssf_status_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
    sssf_spi_master sssf_spi_master_i (.sclk(spi_sclk), .mosi(spi_mosi), .ss_n(spi_ss_n), .miso(spi_miso));

    // Free-running 100 MHz module clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Prints the counts and the verdict, then stops.
    task conclude;
        begin
            $display("Checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask

    // Counts a comparison and reports a mismatch.
    task chk(input [31:0] s, input [31:0] e, input [8*12:1] nm);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask

    // One-cycle write strobe.
    task wr(input [`SSSF_ADDR_W-1:0] a, input [31:0] v);
        begin
            @(posedge core_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= v;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask

    // One-cycle read strobe; the answer is taken mid-cycle after it.
    task rd(input [`SSSF_ADDR_W-1:0] a);
        begin
            @(posedge core_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            @(negedge core_clk);
            d = reg_rdata;
        end
    endtask

    // Reads a register and compares the masked value.
    task rchk(input [`SSSF_ADDR_W-1:0] a, input [31:0] m, input [31:0] e, input [8*12:1] nm);
        begin
            rd(a);
            chk(d & m, e, nm);
        end
    endtask

    // Polls status until the masked value appears, within a bounded number of reads.
    task poll(input [31:0] m, input [31:0] e);
        integer t;
        begin
            t = 0;
            rd(`SSSF_ADDR_STATUS);
            while ((d & m) !== e && t < 100) begin
                rd(`SSSF_ADDR_STATUS);
                t = t + 1;
            end
            chk(d & m, e, "poll");
            if ((d & m) !== e) begin
                conclude;
            end
        end
    endtask

    // Cuts a hang short.
    initial begin
        #900000;
        chk(32'h0000_0000, 32'h0000_0001, "watchdog");
        conclude;
    end

    // Main sequence.
    initial begin
        n_fail = 0;
        n_checks = 0;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = `SSSF_ADDR_CTRL;
        reg_wdata = 32'h0000_0000;
        rows[0] = {`SSSF_ADDR_CTRL, 32'h0000_0000};
        rows[1] = {`SSSF_ADDR_STATUS, `SSSF_STATUS_RST};
        rows[2] = {`SSSF_ADDR_IRQ_STAT, 32'h0000_0000};
        rows[3] = {`SSSF_ADDR_IRQ_MASK, 32'h0000_0000};
        rows[4] = {5'h14, 32'h0000_0000};
        rows[5] = {5'h1C, 32'h0000_0000};
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
            rchk(rows[k][36:32], 32'hFFFF_FFFF, rows[k][31:0], "reset row");
        end
        // Enhanced buffers: counts, activity and a full word each way.
        wr(`SSSF_ADDR_CTRL, 32'h0000_0003);
        wr(`SSSF_ADDR_IRQ_MASK, 32'h0000_000F);
        wr(`SSSF_ADDR_DATA, 32'h0000_00A5);
        wr(`SSSF_ADDR_DATA, 32'h0000_003C);
        rchk(`SSSF_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0002_00A0, "enh idle");
        fork
            sssf_spi_master_i.xfer(8'h5A, 8, rxb);
            begin
                #700;
                rchk(`SSSF_ADDR_STATUS, 32'h0000_0880, 32'h0000_0800, "mid frame");
            end
        join
        chk({24'h00_0000, rxb}, 32'h0000_00A5, "link out");
        poll(32'h1F00_0000, 32'h0100_0000);
        rchk(`SSSF_ADDR_STATUS, 32'h1F1F_0029, 32'h0100_0008, "enh rx one");
        rchk(`SSSF_ADDR_DATA, 32'hFFFF_FFFF, 32'h0000_005A, "rx word");
        chk({31'h000_0000, irq}, 32'h0000_0001, "irq high");
        wr(`SSSF_ADDR_IRQ_MASK, 32'h0000_0000);
        rchk(`SSSF_ADDR_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0008, "rx event");
        chk({31'h000_0000, irq}, 32'h0000_0000, "irq masked");
        wr(`SSSF_ADDR_IRQ_MASK, 32'h0000_000F);
        wr(`SSSF_ADDR_IRQ_STAT, 32'h0000_000F);
        rchk(`SSSF_ADDR_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0000, "irq cleared");
        chk({31'h000_0000, irq}, 32'h0000_0000, "irq low");
        rchk(`SSSF_ADDR_STATUS, 32'h1F00_0020, 32'h0000_0020, "rx empty");
        // Single-word buffers: second word overflows and is dropped.
        wr(`SSSF_ADDR_CTRL, 32'h0000_0000);
        wr(`SSSF_ADDR_CTRL, 32'h0000_0001);
        wr(`SSSF_ADDR_DATA, 32'h0000_0077);
        rchk(`SSSF_ADDR_STATUS, 32'h0000_0002, 32'h0000_0002, "tx full");
        sssf_spi_master_i.xfer(8'h11, 8, rxb);
        sssf_spi_master_i.xfer(8'h22, 8, rxb);
        poll(32'h0000_0040, 32'h0000_0040);
        rchk(`SSSF_ADDR_STATUS, 32'h1F1F_0043, 32'h0100_0041, "overflow");
        rchk(`SSSF_ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001, "ovf event");
        rchk(`SSSF_ADDR_DATA, 32'hFFFF_FFFF, 32'h0000_0011, "kept word");
        wr(`SSSF_ADDR_STATUS, 32'h0000_0040);
        rchk(`SSSF_ADDR_STATUS, 32'h0000_0040, 32'h0000_0040, "one keeps");
        wr(`SSSF_ADDR_STATUS, 32'h0000_0000);
        rchk(`SSSF_ADDR_STATUS, 32'h0000_0040, 32'h0000_0000, "zero clears");
        // Framed mode: word abandoned with the transmit buffer empty.
        wr(`SSSF_ADDR_CTRL, 32'h0000_0000);
        wr(`SSSF_ADDR_CTRL, 32'h0000_0005);
        sssf_spi_master_i.xfer(8'hC3, 4, rxb);
        poll(32'h0000_1000, 32'h0000_1000);
        rchk(`SSSF_ADDR_STATUS, 32'h0000_1100, 32'h0000_1100, "framed err");
        wr(`SSSF_ADDR_CTRL, 32'h0000_0004);
        wr(`SSSF_ADDR_CTRL, 32'h0000_0005);
        rchk(`SSSF_ADDR_STATUS, 32'h0000_1100, 32'h0000_1000, "re-enable");
        wr(`SSSF_ADDR_STATUS, 32'h0000_0000);
        rchk(`SSSF_ADDR_STATUS, 32'h0000_1000, 32'h0000_0000, "frm clear");
        conclude;
    end
endmodule
